/* File: dv/ccc_chain_tb_top.sv */
// self-checking bench of the calibration correction chain
`timescale 1ns/1ps
module ccc_chain_tb_top import ccc_pkg::*;;
  logic clk, nrst, cal_busy, cal_done, ser_load, ser_shift, ser_din, ser_commit, ser_dout;
  logic raw_valid, raw_ready, out_valid, out_ready, cont_active, cont_refused;
  logic [1:0] ser_sel;
  logic [DW-1:0] raw_data, out_data, rd;
  logic [RW-1:0] rate_msps;
  ccc_ctrl_t ctrl;
  ccc_cal_t cal;
  int errors, compares;
  int lf0[8] = '{1000, 2500, 5000, 10000, 15000, 30000, 60000, 120000};
  int lf1[8] = '{833, 2080, 4170, 8330, 12500, 25000, 50000, 100000};
  // result register plus eight fifo words
  localparam int FIFO_N = 9;

  ccc_chain ccc_chain_i (.clk(clk), .nrst(nrst), .ctrl(ctrl), .cal_busy(cal_busy),
    .cal_done(cal_done), .cal(cal), .ser_sel(ser_sel), .ser_load(ser_load),
    .ser_shift(ser_shift), .ser_din(ser_din), .ser_commit(ser_commit), .ser_dout(ser_dout),
    .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_data(raw_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .rate_msps(rate_msps), .cont_active(cont_active), .cont_refused(cont_refused));
  ccc_host_model ccc_host_model_i (.clk(clk), .ser_sel(ser_sel), .ser_load(ser_load),
    .ser_shift(ser_shift), .ser_din(ser_din), .ser_commit(ser_commit), .ser_dout(ser_dout));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [DW-1:0] got, logic [DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic limit(int n);
    if (n >= 50) begin
      errors++;
      $display("Error wait expected done seen timeout");
      conclude();
    end
  endtask
  // one word through the chain, result compared
  task automatic proc(logic [DW-1:0] raw, logic [DW-1:0] exp);
    int n;
    n = 0;
    raw_data = raw;
    raw_valid = 1'b1;
    while (raw_ready !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    tick();
    raw_valid = 1'b0;
    while (out_valid !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    limit(n);
    chk("out_data", out_data, exp);
    tick();
  endtask

  task automatic t_regs();
    logic [DW-1:0] v[4] = '{24'h7fffff, 24'h0000c8, 24'h200000, 24'h000064};
    for (int s = 0; s < 3; s++) begin
      ccc_host_model_i.xfer(2'(s), 24'h000000, 1'b0, rd);
      chk("coef reset", rd, COEF_RST);
    end
    for (int s = 0; s < 4; s++) ccc_host_model_i.xfer(2'(s), v[s], 1'b1, rd);
    for (int s = 0; s < 3; s++) begin
      ccc_host_model_i.xfer(2'(s), 24'h000000, 1'b0, rd);
      chk("coef readback", rd, v[s]);
    end
  endtask
  task automatic t_chain();
    proc(24'h0003e8, 24'h0003e8);
    ctrl.self_offset_disable = 1'b0;
    proc(24'h0003e8, 24'h000320);
    proc(24'hfffc18, 24'hfffb50);
    ctrl.self_gain_disable = 1'b0;
    proc(24'h0003e8, 24'h000190);
    ctrl.system_offset_disable = 1'b0;
    proc(24'h0003e8, 24'h00012c);
    ctrl.unipolar = 1'b1;
    proc(24'h0003e8, 24'h000258);
    ctrl.system_gain_disable = 1'b0;
    proc(24'h0003e8, 24'h0004b0);
    ctrl.dgain = 3'h2;
    proc(24'h0003e8, 24'h0012c0);
    proc(24'h7fffff, OUT_MAX);
    proc(24'h800000, OUT_MIN);
    ctrl = '1;
    ctrl.unipolar = 1'b0;
    ctrl.dgain = 3'h0;
    ctrl.cont_req = 1'b0;
    ctrl.self_gain_disable = 1'b0;
    proc(24'h0003e8, 24'h0001f4);
    ctrl.self_gain_disable = 1'b1;
    ctrl.system_offset_disable = 1'b0;
    proc(24'h0003e8, 24'h000384);
    ctrl.system_offset_disable = 1'b1;
    ctrl.unipolar = 1'b1;
    proc(24'h0003e8, 24'h0007d0);
    ctrl.unipolar = 1'b0;
    ctrl.dgain = 3'h3;
    proc(24'h0003e8, 24'h001f40);
    ctrl.dgain = 3'h7;
    proc(24'h100000, OUT_MAX);
    ctrl.dgain = 3'h0;
  endtask
  task automatic t_cal();
    cal = '{1'b1, 24'h000010, 24'h400000};
    cal_done = 1'b1;
    tick();
    cal_done = 1'b0;
    ccc_host_model_i.xfer(SEL_SELF_OFF, 24'h000000, 1'b0, rd);
    chk("self offset cal", rd, 24'h000010);
    cal_busy = 1'b1;
    ccc_host_model_i.xfer(SEL_SELF_GAIN, 24'h123456, 1'b1, rd);
    cal_busy = 1'b0;
    ccc_host_model_i.xfer(SEL_SELF_GAIN, 24'h000000, 1'b0, rd);
    chk("self gain busy", rd, 24'h400000);
    cal = '{1'b0, 24'h000020, 24'h400000};
    cal_done = 1'b1;
    tick();
    cal_done = 1'b0;
    ccc_host_model_i.xfer(SEL_SYS_OFF, 24'h000000, 1'b0, rd);
    chk("system offset cal", rd, 24'h000020);
  endtask
  task automatic t_rate();
    int r;
    for (int i = 0; i < 16; i++) begin
      ctrl.line_frequency_select = i[3];
      ctrl.rate = i[2:0];
      ctrl.cont_req = 1'b1;
      tick();
      r = i[3] ? lf1[i % 8] : lf0[i % 8];
      if (i[2]) r = r * 4;
      chk("rate", {4'h0, rate_msps}, r[23:0]);
      chk("cont", {23'h0, cont_active}, {23'h0, i[2]});
      chk("refused", {23'h0, cont_refused}, {23'h0, ~i[2]});
    end
    ctrl.cont_req = 1'b0;
  endtask
  task automatic t_fifo();
    int acc, n;
    acc = 0;
    out_ready = 1'b0;
    raw_data = 24'h000000;
    raw_valid = 1'b1;
    for (int k = 0; k < 20; k++) begin
      if (raw_ready === 1'b1) acc++;
      tick();
      raw_data = 24'(acc);
    end
    raw_valid = 1'b0;
    chk("fill count", 24'(acc), 24'(FIFO_N));
    out_ready = 1'b1;
    for (int k = 0; k < acc; k++) begin
      n = 0;
      while (out_valid !== 1'b1 && n < 50) begin
        tick();
        n++;
      end
      limit(n);
      chk("drain", out_data, 24'(k));
      tick();
    end
    tick();
    chk("empty", {23'h0, out_valid}, 24'h000000);
  endtask

  initial begin
    errors = 0;
    compares = 0;
    nrst = 1'b0;
    ctrl = '1;
    ctrl.unipolar = 1'b0;
    ctrl.line_frequency_select = 1'b0;
    ctrl.rate = 3'h0;
    ctrl.cont_req = 1'b0;
    ctrl.dgain = 3'h0;
    cal_busy = 1'b0;
    cal_done = 1'b0;
    cal = '0;
    raw_valid = 1'b0;
    raw_data = 24'h000000;
    out_ready = 1'b1;
    repeat (10) tick();
    nrst = 1'b1;
    chk("ser_dout", {23'h0, ser_dout}, 24'h000000);
    chk("raw_ready", {23'h0, raw_ready}, 24'h000001);
    t_regs();
    t_chain();
    t_cal();
    t_rate();
    t_fifo();
    conclude();
  end
endmodule // ccc_chain_tb_top

/* File: dv/ccc_host_model.sv */
// host model driving the serial coefficient port
`timescale 1ns/1ps
module ccc_host_model import ccc_pkg::*; (
  // clock
  input wire logic clk,
  // serial port
  output logic [1:0] ser_sel,
  output logic ser_load,
  output logic ser_shift,
  output logic ser_din,
  output logic ser_commit,
  input wire logic ser_dout
);
  initial begin
    ser_sel = SEL_SYS_GAIN;
    ser_load = 1'b0;
    ser_shift = 1'b0;
    ser_din = 1'b0;
    ser_commit = 1'b0;
  end

  // load, 24 shifts, optional commit; read data comes back on ser_dout
  task automatic xfer(input logic [1:0] sel, input logic [DW-1:0] wd, input logic wr,
                      output logic [DW-1:0] rd);
    ser_sel = sel;
    ser_load = 1'b1;
    @(posedge clk);
    #1;
    ser_load = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      rd[i] = ser_dout;
      ser_din = wd[i];
      ser_shift = 1'b1;
      @(posedge clk);
      #1;
    end
    ser_shift = 1'b0;
    ser_din = ~ser_din;
    ser_commit = wr;
    @(posedge clk);
    #1;
    ser_commit = 1'b0;
  endtask
endmodule // ccc_host_model

/* File: rtl/ccc_chain.sv */
// calibration correction chain with coefficient registers and rate select
//
// Operation
// - self-offset coefficient: 24-bit read/write, shifted MSB first.
// - self-offset coefficient is signed two's complement self-calibration offset.
// - host-written self coefficients stay until rewritten or replaced by self-calibration.
// - subtract self-offset from every result when its disable bit is 0.
// - self-offset subtraction comes before self-gain and both system corrections.
// - self-offset correction precedes the unipolar doubling.
// - self-gain coefficient: 24-bit read/write two's complement, MSB first.
// - host write to self-gain during calibration is discarded.
// - self-gain multiplies the self-offset-corrected result when enabled.
// - self-gain scale reaches up to double.
// - gain result is within two LSB of ideal.
// - line select 0: documented single and continuous rates per rate code.
// - line select 1: documented single and continuous rates per rate code.
// - continuous only for rate codes 100 to 111; host must not ask otherwise.
// - programmable digital gain is a binary left shift of corrected data.
// - system offset subtracted after self corrections, before system gain.
// - system gain scales the offset-corrected result after unipolar doubling, before the digital gain shift.
// - out-of-range results clamp to minimum or maximum code.
`timescale 1ns/1ps
module ccc_chain import ccc_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control bits
  input wire ccc_ctrl_t ctrl,
  input wire logic cal_busy,
  // calibration results
  input wire logic cal_done,
  input wire ccc_cal_t cal,
  // serial register port
  input wire logic [1:0] ser_sel,
  input wire logic ser_load,
  input wire logic ser_shift,
  input wire logic ser_din,
  input wire logic ser_commit,
  output logic ser_dout,
  // raw conversion input
  input wire logic raw_valid,
  output logic raw_ready,
  input wire logic [DW-1:0] raw_data,
  // corrected output
  output logic out_valid,
  input wire logic out_ready,
  output logic [DW-1:0] out_data,
  // rate select
  output logic [RW-1:0] rate_msps,
  output logic cont_active,
  output logic cont_refused
);
  typedef struct packed {
    logic [DW-1:0] system_gain_coefficient;
    logic [DW-1:0] self_offset_coefficient;
    logic [DW-1:0] self_gain_coefficient;
    logic [DW-1:0] system_offset_coefficient;
    logic [DW-1:0] shift;
    logic pv;
    logic [DW-1:0] pdata;
    logic [RW-1:0] rate;
    logic cont;
    logic cont_bad;
  } ccc_st_t;

  ccc_st_t st_r, st_nxt;
  logic fifo_in_ready;
  logic take;
  logic signed [XW-1:0] x_in, x_so, x_sg, x_sys_o, x_uni, x_sys_g, x_dg;
  logic [RW-1:0] rate_single;
  logic signed [2*DW-1:0] gain_ideal;

  // clamp to output range
  function automatic logic signed [XW-1:0] sat(input logic signed [XW-1:0] v);
    if (v > XW'(OUT_MAX)) begin
      return XW'(OUT_MAX);
    end else if (v < XW'(OUT_MIN)) begin
      return XW'(OUT_MIN);
    end
    return v;
  endfunction

  // up to double, rounded
  // gain multiply, coefficient 2.22 fixed point
  function automatic logic signed [XW-1:0] gmul(input logic signed [XW-1:0] a,
                                               input logic [DW-1:0] c);
    logic signed [XW-1:0] p;
    p = a * XW'($signed(c));
    p = p + (XW'(1) <<< (GAIN_FRAC - 1));
    return sat(p >>> GAIN_FRAC);
  endfunction

  assign x_in = XW'($signed(raw_data));

  always_comb begin
    x_so = ctrl.self_offset_disable ? x_in
         : sat(x_in - XW'($signed(st_r.self_offset_coefficient)));
    x_sg = ctrl.self_gain_disable ? x_so : gmul(x_so, st_r.self_gain_coefficient);
    x_sys_o = ctrl.system_offset_disable ? x_sg
            : sat(x_sg - XW'($signed(st_r.system_offset_coefficient)));
    x_uni = ctrl.unipolar ? sat(x_sys_o <<< 1) : x_sys_o;
    x_sys_g = ctrl.system_gain_disable ? x_uni
            : gmul(x_uni, st_r.system_gain_coefficient);
    x_dg = sat(x_sys_g <<< ctrl.dgain);
  end

  assign rate_single = ctrl.line_frequency_select ? RATE_LF1_MSPS[ctrl.rate]
                     : RATE_LF0_MSPS[ctrl.rate];

  assign raw_ready = !st_r.pv || fifo_in_ready;
  assign take = raw_valid && raw_ready;

  always_comb begin
    st_nxt = st_r;
    if (ser_load) begin
      unique case (ser_sel)
        SEL_SYS_GAIN: st_nxt.shift = st_r.system_gain_coefficient;
        SEL_SELF_OFF: st_nxt.shift = st_r.self_offset_coefficient;
        SEL_SELF_GAIN: st_nxt.shift = st_r.self_gain_coefficient;
        SEL_SYS_OFF: st_nxt.shift = st_r.system_offset_coefficient;
      endcase
    end else if (ser_shift) begin
      st_nxt.shift = {st_r.shift[DW-2:0], ser_din};
    end
    if (ser_commit) begin
      unique case (ser_sel)
        SEL_SYS_GAIN: st_nxt.system_gain_coefficient = st_r.shift;
        SEL_SELF_OFF: st_nxt.self_offset_coefficient = st_r.shift;
        SEL_SELF_GAIN: begin
          if (!cal_busy) begin
            st_nxt.self_gain_coefficient = st_r.shift;
          end
        end
        SEL_SYS_OFF: st_nxt.system_offset_coefficient = st_r.shift;
      endcase
    end
    if (cal_done) begin
      if (cal.self_kind) begin
        st_nxt.self_offset_coefficient = cal.offset;
        st_nxt.self_gain_coefficient = cal.gain;
      end else begin
        st_nxt.system_offset_coefficient = cal.offset;
        st_nxt.system_gain_coefficient = cal.gain;
      end
    end
    // result register feeding the fifo
    if (take) begin
      st_nxt.pv = 1'b1;
      st_nxt.pdata = x_dg[DW-1:0];
    end else if (fifo_in_ready) begin
      st_nxt.pv = 1'b0;
    end
    st_nxt.cont = ctrl.cont_req && (ctrl.rate >= RATE_CONT_MIN);
    st_nxt.cont_bad = ctrl.cont_req && (ctrl.rate < RATE_CONT_MIN);
    st_nxt.rate = st_nxt.cont ? (rate_single << CONT_SHIFT) : rate_single;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r.system_gain_coefficient <= COEF_RST;
      st_r.self_offset_coefficient <= COEF_RST;
      st_r.self_gain_coefficient <= COEF_RST;
      st_r.system_offset_coefficient <= COEF_RST;
      st_r.shift <= SHIFT_RST;
      st_r.pv <= 1'b0;
      st_r.pdata <= '0;
      st_r.rate <= '0;
      st_r.cont <= 1'b0;
      st_r.cont_bad <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ser_dout = st_r.shift[DW-1];
  assign rate_msps = st_r.rate;
  assign cont_active = st_r.cont;
  assign cont_refused = st_r.cont_bad;

  ccc_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(st_r.pv),
    .in_ready(fifo_in_ready),
    .in_data(st_r.pdata),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // assertions
  AST_BUSY_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    (ser_commit && ser_sel == SEL_SELF_GAIN && cal_busy && !cal_done)
    |=> st_r.self_gain_coefficient == $past(st_r.self_gain_coefficient))
    else $error("self gain written during calibration");
  AST_HOST_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    (ser_commit && ser_sel == SEL_SELF_OFF && !cal_done)
    |=> st_r.self_offset_coefficient == $past(st_r.shift))
    else $error("self offset write lost");
  AST_CAL_REPLACE: assert property (@(posedge clk) disable iff (!nrst)
    (cal_done && cal.self_kind)
    |=> st_r.self_gain_coefficient == $past(cal.gain)
        && st_r.self_offset_coefficient == $past(cal.offset))
    else $error("self calibration result not stored");
  AST_SHIFT_MSB: assert property (@(posedge clk) disable iff (!nrst)
    (ser_shift && !ser_load) ##1 ser_shift [*8] |-> ##1
    ser_dout == $past(st_r.shift[DW-10], 9))
    else $error("serial shift not msb first");
  AST_PASS_THROUGH: assert property (@(posedge clk) disable iff (!nrst)
    (take && ctrl.self_offset_disable && ctrl.self_gain_disable
     && ctrl.system_offset_disable && ctrl.system_gain_disable
     && !ctrl.unipolar && ctrl.dgain == 3'h0)
    |=> st_r.pdata == $past(raw_data))
    else $error("disabled stages altered data");
  AST_OFFSET_SUB: assert property (@(posedge clk) disable iff (!nrst)
    (take && !ctrl.self_offset_disable && ctrl.self_gain_disable
     && ctrl.system_offset_disable && ctrl.system_gain_disable
     && !ctrl.unipolar && ctrl.dgain == 3'h0
     && raw_data[DW-1] == raw_data[DW-2]
     && st_r.self_offset_coefficient[DW-1] == st_r.self_offset_coefficient[DW-2])
    |=> st_r.pdata == $past(raw_data - st_r.self_offset_coefficient))
    else $error("self offset not subtracted");
  AST_CLAMP: assert property (@(posedge clk) disable iff (!nrst)
    (take && ctrl.dgain == 3'h7 && $signed(raw_data) > 24'sh0fffff
     && ctrl.self_offset_disable && ctrl.self_gain_disable
     && ctrl.system_offset_disable && ctrl.system_gain_disable && !ctrl.unipolar)
    |=> st_r.pdata == OUT_MAX)
    else $error("overflow not clamped");
  AST_CONT_RULE: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.cont_req && ctrl.rate < RATE_CONT_MIN) |=> cont_refused && !cont_active)
    else $error("continuous allowed on low rate code");
  AST_RATE_CONT: assert property (@(posedge clk) disable iff (!nrst)
    (!ctrl.line_frequency_select && ctrl.cont_req && ctrl.rate == 3'h7)
    |=> rate_msps == 20'h75300)
    else $error("continuous rate wrong");
  AST_NO_LOSS: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.pv && !fifo_in_ready) |=> st_r.pv && $stable(st_r.pdata))
    else $error("stalled result dropped");
  // truncated ideal product for the gain check
  assign gain_ideal = (2*DW)'($signed(raw_data))
                    * (2*DW)'($signed(st_r.self_gain_coefficient));
  AST_SELF_GAIN: assert property (@(posedge clk) disable iff (!nrst)
    (take && ctrl.self_offset_disable && !ctrl.self_gain_disable
     && ctrl.system_offset_disable && ctrl.system_gain_disable
     && !ctrl.unipolar && ctrl.dgain == 3'h0 && raw_data[DW-1] == raw_data[DW-2]
     && !st_r.self_gain_coefficient[DW-1])
    |=> (st_r.pdata - $past(gain_ideal[GAIN_FRAC +: DW])) <= 24'h000002)
    else $error("self gain result off by more than two codes");
  AST_SYS_OFFSET: assert property (@(posedge clk) disable iff (!nrst)
    (take && ctrl.self_offset_disable && ctrl.self_gain_disable
     && !ctrl.system_offset_disable && ctrl.system_gain_disable
     && !ctrl.unipolar && ctrl.dgain == 3'h0 && raw_data[DW-1] == raw_data[DW-2]
     && st_r.system_offset_coefficient[DW-1] == st_r.system_offset_coefficient[DW-2])
    |=> st_r.pdata == $past(raw_data - st_r.system_offset_coefficient))
    else $error("system offset not subtracted");
  AST_UNIPOLAR: assert property (@(posedge clk) disable iff (!nrst)
    (take && ctrl.self_offset_disable && ctrl.self_gain_disable
     && ctrl.system_offset_disable && ctrl.system_gain_disable
     && ctrl.unipolar && ctrl.dgain == 3'h0 && raw_data[DW-1] == raw_data[DW-2])
    |=> st_r.pdata == $past({raw_data[DW-2:0], 1'b0}))
    else $error("unipolar result not doubled");
  AST_DGAIN: assert property (@(posedge clk) disable iff (!nrst)
    (take && ctrl.self_offset_disable && ctrl.self_gain_disable
     && ctrl.system_offset_disable && ctrl.system_gain_disable
     && !ctrl.unipolar && ctrl.dgain != 3'h0 && raw_data[DW-1:DW-8] == 8'h00)
    |=> st_r.pdata == $past(raw_data << ctrl.dgain))
    else $error("digital gain not a left shift");
  AST_LOAD_OFFSET: assert property (@(posedge clk) disable iff (!nrst)
    (ser_load && ser_sel == SEL_SELF_OFF)
    |=> st_r.shift == $past(st_r.self_offset_coefficient))
    else $error("self offset not loaded for read");
  AST_LOAD_GAIN: assert property (@(posedge clk) disable iff (!nrst)
    (ser_load && ser_sel == SEL_SELF_GAIN)
    |=> st_r.shift == $past(st_r.self_gain_coefficient))
    else $error("self gain not loaded for read");
  AST_RATE_SINGLE: assert property (@(posedge clk) disable iff (!nrst)
    (!ctrl.line_frequency_select && !ctrl.cont_req && ctrl.rate == 3'h0)
    |=> rate_msps == 20'h003e8)
    else $error("single rate wrong");
  AST_RATE_LF1: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.line_frequency_select && ctrl.cont_req && ctrl.rate == 3'h7)
    |=> rate_msps == 20'h61a80)
    else $error("line select continuous rate wrong");
  AST_CONT_OK: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.cont_req && ctrl.rate >= RATE_CONT_MIN) |=> cont_active && !cont_refused)
    else $error("continuous refused on high rate code");
endmodule // ccc_chain

/* File: rtl/ccc_fifo.sv */
// parameterised flip-flop fifo for corrected results
`timescale 1ns/1ps
module ccc_fifo import ccc_pkg::*; #(
  parameter int W = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ccc_fifo_st_t;

  ccc_fifo_st_t st_r, st_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (st_r.cnt != DEPTH_C);
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = inc(st_r.wp);
    end
    if (pop) begin
      st_nxt.rp = inc(st_r.rp);
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // ccc_fifo

/* File: rtl/ccc_pkg.sv */
// shared constants and types of the calibration correction chain
package ccc_pkg;
  localparam int DW = 24;
  localparam int XW = 50;
  localparam int GAIN_FRAC = 22;
  localparam int RW = 20;
  localparam logic [DW-1:0] COEF_RST = 24'h000000;
  localparam logic signed [DW-1:0] OUT_MAX = 24'sh7fffff;
  localparam logic signed [DW-1:0] OUT_MIN = -24'sh800000;
  localparam logic [DW-1:0] SHIFT_RST = 24'h000000;
  // serial register selects
  localparam logic [1:0] SEL_SYS_GAIN = 2'h0;
  localparam logic [1:0] SEL_SELF_OFF = 2'h1;
  localparam logic [1:0] SEL_SELF_GAIN = 2'h2;
  localparam logic [1:0] SEL_SYS_OFF = 2'h3;
  // first rate code that offers continuous conversion
  localparam logic [2:0] RATE_CONT_MIN = 3'h4;
  localparam int CONT_SHIFT = 2;
  // single-conversion rates in milli-samples per second, index = rate code
  localparam logic [7:0][RW-1:0] RATE_LF0_MSPS = {
    20'h1d4c0, 20'h0ea60, 20'h07530, 20'h03a98,
    20'h02710, 20'h01388, 20'h009c4, 20'h003e8};
  localparam logic [7:0][RW-1:0] RATE_LF1_MSPS = {
    20'h186a0, 20'h0c350, 20'h061a8, 20'h030d4,
    20'h0208a, 20'h0104a, 20'h00820, 20'h00341};

  typedef struct packed {
    logic self_offset_disable;
    logic self_gain_disable;
    logic system_offset_disable;
    logic system_gain_disable;
    logic unipolar;
    logic line_frequency_select;
    logic [2:0] rate;
    logic cont_req;
    logic [2:0] dgain;
  } ccc_ctrl_t;

  typedef struct packed {
    logic self_kind;
    logic [DW-1:0] offset;
    logic [DW-1:0] gain;
  } ccc_cal_t;
endpackage
